// File: uart_ctl_defs.vh
// Constants for the second serial control register block.
// Assumes inclusion by bare name from the design files.
`ifndef UART_CTL_DEFS_VH
`define UART_CTL_DEFS_VH
// ==========================================================
// Register byte addresses
`define OFS_CTRL2 4'h0
`define OFS_MODE 4'h4
`define OFS_IRQ_STAT 4'h8
`define OFS_FLAGS 4'hc
// ==========================================================
// Control register two fields
`define B_TX_EMPTY_IRQ_EN 7
`define B_TX_DONE_IRQ_EN 6
`define B_RX_FULL_IRQ_EN 5
`define B_RX_QUIET_IRQ_EN 4
`define B_TX_ON 3
`define B_RX_ON 2
`define B_RX_STANDBY 1
`define B_BREAK_QUEUE 0
`define CTRL2_RESET 8'h00
// ==========================================================
// Mode register fields
`define B_LOOPBACK_SEL 0
`define B_RX_SOURCE_SEL 1
`define B_SINGLE_WIRE_DIR 2
`define B_CHAR_LEN_SEL 3
`define B_STANDBY_EXIT 4
`define MODE_RESET 5'h00
// ==========================================================
// Character timing
`define BITS_CHAR_SHORT 4'ha
`define BITS_CHAR_LONG 4'hb
`define BIT_CYCLES 16
// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: bit_tick.v
// Bit time divider: one-cycle tick every DIV clock cycles.
// Assumes a restart pulse aligns the first tick to a frame start.
`timescale 1ns/1ps
module bit_tick #(
  parameter DIV = 16
) (
  input wire clk_i,
  input wire rstn_i,
  input wire restart_i,
  output reg tick_o
);
  reg [15:0] cnt_q;
  // ==========================================================
  // Divider
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      // Restart cycle is the first of the bit; needs DIV of two or more
      cnt_q <= 16'h0001;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// File: uart_ctl2.v
// Second serial control register: interrupt gating, enables,
// pin ownership, queued idle and break characters, rx standby.
// Assumes the data shifter, receiver and flags live outside and
// are synchronous to CLK_I.
`timescale 1ns/1ps
`include "uart_ctl_defs.vh"
// How it works
// - Control register reads and writes are accepted at any time.
// - Bit 7 gates the transmit buffer empty flag onto the interrupt.
// - Bit 6 gates the transmit done flag onto the interrupt.
// - Bit 5 gates the receive buffer full flag onto the interrupt.
// - Bit 4 gates the line quiet flag onto the interrupt.
// - Bit 3 enables transmitter; it then drives the transmit pin.
// - Internal loopback returns the transmit pin to general I/O.
// - In single-wire mode the direction bit sets pin direction.
// - Turning tx_on off then on queues one idle character.
// - Transmitter keeps the pin until pending characters finish.
// - Bit 2 enables receiver; when off, receive pin goes to I/O.
// - Bit 1 puts receiver in standby until wakeup clears it.
// - Wakeup is idle line, or set data MSB when method bit is one.
// - Writing one then zero to bit 0 queues one break.
// - While bit 0 stays one, break characters keep being queued.
// - Idle and break last 10 or 11 bits per char length select.
// - Loopback with receive source on forms single-wire mode.
// - Transmit done is one after reset and while fully idle.
module uart_ctl2 #(
  parameter BIT_DIV = `BIT_CYCLES
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire [3:0] AWADDR_I,
  input wire AWVALID_I,
  output reg AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output reg WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [3:0] ARADDR_I,
  input wire ARVALID_I,
  output reg ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  input wire TX_BUF_EMPTY_I,
  input wire RX_BUF_FULL_I,
  input wire LINE_QUIET_I,
  input wire TX_BUSY_I,
  input wire TX_SHIFT_I,
  input wire RX_IDLE_WAKE_I,
  input wire RX_CHAR_DONE_I,
  input wire RX_CHAR_MSB_I,
  input wire TXD_I,
  input wire RXD_I,
  output reg TXD_O,
  output reg TXD_OE_O,
  output reg TXD_GPIO_O,
  output reg RXD_GPIO_O,
  output reg RX_LINE_O,
  output reg RX_ENABLE_O,
  output reg RX_STANDBY_O,
  output reg TX_HOLD_O,
  output reg TX_DONE_O,
  output reg IRQ_O
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_BRK = 2'h2;

  reg [7:0] ctrl2_q;
  reg [4:0] mode_q;
  reg [7:4] sticky_q;
  reg [7:4] flags_prev_q;
  reg have_aw_q;
  reg have_w_q;
  reg [3:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg idle_pend_q;
  reg brk_pend_q;
  reg [1:0] state_q;
  reg [3:0] bits_q;
  reg tx_done_q;
  reg restart;
  reg [7:4] flags;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  wire tick;
  wire do_write;
  wire wr_ctrl2;
  wire wr_mode;
  wire rd_take;
  wire rd_stat;
  wire [7:0] wbyte;
  wire [3:0] char_bits;
  wire loop;
  wire rx_source_sel;
  wire tx_owns;
  wire wake;
  wire tx_line;
  wire char_end;
  wire next_pend;

  // Address check used by the write response path
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `OFS_CTRL2) || (a == `OFS_MODE) ||
               (a == `OFS_IRQ_STAT) || (a == `OFS_FLAGS);
    end
  endfunction

  // ==========================================================
  // Bit timer
  bit_tick #(
    .DIV(BIT_DIV)
  ) u_tick (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .restart_i(restart),
    .tick_o(tick)
  );

  // Decoded strobes and modes
  assign do_write = have_aw_q & have_w_q & ~BVALID_O;
  assign wbyte = wdata_q[7:0];
  assign wr_ctrl2 = do_write & wstrb_q[0] & (waddr_q == `OFS_CTRL2);
  assign wr_mode = do_write & wstrb_q[0] & (waddr_q == `OFS_MODE);
  assign rd_take = ARVALID_I & ARREADY_O;
  assign rd_stat = rd_take & (ARADDR_I == `OFS_IRQ_STAT);
  assign loop = mode_q[`B_LOOPBACK_SEL];
  assign rx_source_sel = mode_q[`B_RX_SOURCE_SEL];
  assign char_bits = mode_q[`B_CHAR_LEN_SEL] ? `BITS_CHAR_LONG :
                     `BITS_CHAR_SHORT;
  // Pin held while enabled or while anything still goes out
  assign tx_owns = ctrl2_q[`B_TX_ON] | TX_BUSY_I |
                   (state_q != ST_IDLE) | idle_pend_q | brk_pend_q;
  assign wake = mode_q[`B_STANDBY_EXIT] ?
                (RX_CHAR_DONE_I & RX_CHAR_MSB_I) :
                RX_IDLE_WAKE_I;
  assign tx_line = (state_q == ST_BRK) ? 1'b0 :
                   (state_q == ST_PRE) ? 1'b1 : TX_SHIFT_I;
  assign char_end = (state_q != ST_IDLE) & tick &
                    (bits_q == char_bits - 4'h1);
  assign next_pend = ~TX_BUSY_I & (idle_pend_q | brk_pend_q |
                     ctrl2_q[`B_BREAK_QUEUE]);

  // ==========================================================
  // AXI4-Lite write channel, address and data in either order
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      waddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= `RESP_OKAY;
    end else begin
      if (AWVALID_I & AWREADY_O) begin
        have_aw_q <= 1'b1;
        waddr_q <= AWADDR_I;
        AWREADY_O <= 1'b0;
      end
      if (WVALID_I & WREADY_O) begin
        have_w_q <= 1'b1;
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
        WREADY_O <= 1'b0;
      end
      if (do_write) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (BVALID_O & BREADY_I) begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  // Read data mux
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `RESP_OKAY;
    case (ARADDR_I)
      `OFS_CTRL2: rdata_d[7:0] = ctrl2_q;
      `OFS_MODE: rdata_d[4:0] = mode_q;
      `OFS_IRQ_STAT: rdata_d[7:4] = sticky_q;
      `OFS_FLAGS: begin
        rdata_d[7:4] = flags;
        rdata_d[3] = tx_owns;
        rdata_d[1] = ctrl2_q[`B_RX_STANDBY];
      end
      default: rresp_d = `RESP_SLVERR;
    endcase
  end

  // ==========================================================
  // AXI4-Lite read channel
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `RESP_OKAY;
    end else if (rd_take) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rdata_d;
      RRESP_O <= rresp_d;
    end else if (RVALID_O & RREADY_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  // ==========================================================
  // Control and mode registers
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ctrl2_q <= `CTRL2_RESET;
      mode_q <= `MODE_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= wbyte[4:0];
      end
      if (wr_ctrl2) begin
        ctrl2_q <= wbyte;
      end else if (wake) begin
        ctrl2_q[`B_RX_STANDBY] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Queued idle and break requests
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      idle_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (wr_ctrl2 & wbyte[`B_TX_ON] & ~ctrl2_q[`B_TX_ON]) begin
        idle_pend_q <= 1'b1;
      end else if (restart & idle_pend_q) begin
        idle_pend_q <= 1'b0;
      end
      if (wr_ctrl2 & wbyte[`B_BREAK_QUEUE]) begin
        brk_pend_q <= 1'b1;
      end else if (restart & ~idle_pend_q) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Idle and break character sequencer
  always @* begin
    restart = 1'b0;
    if ((state_q == ST_IDLE) | char_end) begin
      restart = next_pend;
    end
  end

  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
      bits_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          bits_q <= 4'h0;
          if (restart) begin
            state_q <= idle_pend_q ? ST_PRE : ST_BRK;
          end
        end
        ST_PRE, ST_BRK: begin
          if (char_end) begin
            bits_q <= 4'h0;
            state_q <= ~restart ? ST_IDLE :
                       idle_pend_q ? ST_PRE : ST_BRK;
          end else if (tick) begin
            bits_q <= bits_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Flag levels seen by the interrupt logic
  always @* begin
    flags[7] = TX_BUF_EMPTY_I;
    flags[6] = tx_done_q;
    flags[5] = RX_BUF_FULL_I;
    flags[4] = LINE_QUIET_I;
  end

  // ==========================================================
  // Transmit done, sticky events, interrupt
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      tx_done_q <= 1'b1;
      flags_prev_q <= 4'h0;
      sticky_q <= 4'h0;
      IRQ_O <= 1'b0;
    end else begin
      tx_done_q <= TX_BUF_EMPTY_I & ~TX_BUSY_I & (state_q == ST_IDLE) &
                   ~restart & ~idle_pend_q & ~brk_pend_q;
      flags_prev_q <= flags;
      // New rising edges win over the clearing read
      sticky_q <= (rd_stat ? 4'h0 : sticky_q) | (flags & ~flags_prev_q);
      IRQ_O <= (ctrl2_q[`B_TX_EMPTY_IRQ_EN] & (flags[7] | sticky_q[7])) |
               (ctrl2_q[`B_TX_DONE_IRQ_EN] & (flags[6] | sticky_q[6])) |
               (ctrl2_q[`B_RX_FULL_IRQ_EN] & (flags[5] | sticky_q[5])) |
               (ctrl2_q[`B_RX_QUIET_IRQ_EN] &
                (flags[4] | sticky_q[4]));
    end
  end

  // ==========================================================
  // Pin ownership and routing
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      TXD_O <= 1'b1;
      TXD_OE_O <= 1'b0;
      TXD_GPIO_O <= 1'b1;
      RXD_GPIO_O <= 1'b1;
      RX_LINE_O <= 1'b1;
      RX_ENABLE_O <= 1'b0;
      RX_STANDBY_O <= 1'b0;
      TX_HOLD_O <= 1'b0;
      TX_DONE_O <= 1'b1;
    end else begin
      TXD_O <= tx_line;
      TXD_GPIO_O <= ~tx_owns | (loop & ~rx_source_sel);
      if (loop & ~rx_source_sel) begin
        TXD_OE_O <= 1'b0;
      end else if (loop & rx_source_sel) begin
        TXD_OE_O <= tx_owns & mode_q[`B_SINGLE_WIRE_DIR];
      end else begin
        TXD_OE_O <= tx_owns;
      end
      if (loop & rx_source_sel) begin
        RX_LINE_O <= TXD_OE_O ? TXD_O : TXD_I;
      end else if (loop) begin
        RX_LINE_O <= tx_line;
      end else begin
        RX_LINE_O <= RXD_I;
      end
      RXD_GPIO_O <= ~ctrl2_q[`B_RX_ON] | loop;
      RX_ENABLE_O <= ctrl2_q[`B_RX_ON];
      RX_STANDBY_O <= ctrl2_q[`B_RX_STANDBY];
      TX_HOLD_O <= (state_q != ST_IDLE); // Lines up with TXD_O
      TX_DONE_O <= tx_done_q;
    end
  end
endmodule

// File: uart_ctl2_properties.sv
// Port checker for the second serial control register.
// Assumes binding onto uart_ctl2 with its bit divider.
`timescale 1ns/1ps
module uart_ctl2_properties #(
  parameter BIT_DIV = 16
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire [3:0] AWADDR_I,
  input wire AWVALID_I,
  input wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire WVALID_I,
  input wire WREADY_O,
  input wire BVALID_O,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire RVALID_O,
  input wire TXD_OE_O,
  input wire TXD_GPIO_O,
  input wire RXD_GPIO_O,
  input wire RX_ENABLE_O,
  input wire TX_HOLD_O,
  input wire TX_DONE_O,
  input wire IRQ_O
);
  // ==========================================
  // Helper state
  wire wr_ok = AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  reg [3:0] en_q;
  reg [9:0] run_q;
  // Enables seen in control writes, length of hold runs
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      en_q <= 4'h0;
      run_q <= 10'h000;
    end else begin
      if (wr_ok && AWADDR_I == 4'h0)
        en_q <= WDATA_I[7:4];
      run_q <= TX_HOLD_O ? run_q + 10'h001 : 10'h000;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  AST_WR_ANSWER: assert property (wr_ok |-> ##2 BVALID_O)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read answer late");
  AST_WR_BUSY: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write accepted while busy");
  AST_DONE_RESET: assert property ($rose(RSTN_I) |-> TX_DONE_O)
    else $error("tx done low after reset");
  AST_DONE_HOLD: assert property (TX_HOLD_O |-> !TX_DONE_O)
    else $error("tx done high while sending");
  AST_OE_OWNER: assert property (TXD_OE_O |-> !TXD_GPIO_O)
    else $error("pin driven while in general use");
  AST_RX_PIN: assert property (!RX_ENABLE_O |-> RXD_GPIO_O)
    else $error("receive pin kept while off");
  AST_IRQ_MASK: assert property (en_q == 4'h0 [*3] |-> !IRQ_O)
    else $error("interrupt with all enables off");
  AST_HOLD_LEN: assert property ($fell(TX_HOLD_O) |->
    (run_q % (10 * BIT_DIV) == 0) || (run_q % (11 * BIT_DIV) == 0))
    else $error("queued character length wrong");
  CV_HOLD: cover property ($rose(TX_HOLD_O));
  CV_IRQ: cover property ($rose(IRQ_O));
  CV_RX_ON: cover property ($fell(RXD_GPIO_O));
endmodule

bind uart_ctl2 uart_ctl2_properties #(.BIT_DIV(BIT_DIV)) props_i (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .AWADDR_I(AWADDR_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
  .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
  .TXD_OE_O(TXD_OE_O), .TXD_GPIO_O(TXD_GPIO_O), .RXD_GPIO_O(RXD_GPIO_O),
  .RX_ENABLE_O(RX_ENABLE_O), .TX_HOLD_O(TX_HOLD_O),
  .TX_DONE_O(TX_DONE_O), .IRQ_O(IRQ_O)
);

// File: line_node.sv
// Remote node on the serial lines, pull-up on the transmit pin.
// Assumes the bench steers its drive controls.
`timescale 1ns/1ps
module line_node (
  input wire dev_val_i,
  input wire dev_oe_i,
  input wire drv_i,
  input wire val_i,
  input wire rx_val_i,
  output wire line_o,
  output wire rx_line_o
);
  // Shared line: device, else node, else pull-up
  assign line_o = dev_oe_i ? dev_val_i : (drv_i ? val_i : 1'b1);
  // Node transmit line toward the receive pin
  assign rx_line_o = rx_val_i;
endmodule

// File: test_uart_ctl2.sv
// Self-checking bench for the second serial control register.
// Assumes the line node model and the bound property checker.
`timescale 1ns/1ps
module test_uart_ctl2;
  localparam BD = 4;
  reg clk, rstn, awv, wv, brdy, arv, rrdy, emp, full, quiet;
  reg wake, cdn, cmsb, ndrv, nval, rxv, busy, shift;
  reg [1:0] resp;
  reg [3:0] awa, ara;
  reg [31:0] wd;
  reg [7:0] d;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire awr, wr_rdy, bv, arr, rv, txd, oe, gpio, rxg, rxl, rxe, stby;
  wire hold, done, irq, pin, rxpin;
  integer errors, checked, cyc, run, last_run, i;
  // ==========================================
  // Design, far-side node, clock
  uart_ctl2 #(.BIT_DIV(BD)) uut (.CLK_I(clk), .RSTN_I(rstn),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(4'h1), .WVALID_I(wv), .WREADY_O(wr_rdy), .BRESP_O(bresp),
    .BVALID_O(bv), .BREADY_I(brdy), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv),
    .RREADY_I(rrdy), .TX_BUF_EMPTY_I(emp), .RX_BUF_FULL_I(full),
    .LINE_QUIET_I(quiet), .TX_BUSY_I(busy), .TX_SHIFT_I(shift),
    .RX_IDLE_WAKE_I(wake), .RX_CHAR_DONE_I(cdn), .RX_CHAR_MSB_I(cmsb),
    .TXD_I(pin), .RXD_I(rxpin), .TXD_O(txd), .TXD_OE_O(oe),
    .TXD_GPIO_O(gpio), .RXD_GPIO_O(rxg), .RX_LINE_O(rxl),
    .RX_ENABLE_O(rxe), .RX_STANDBY_O(stby), .TX_HOLD_O(hold),
    .TX_DONE_O(done), .IRQ_O(irq));
  line_node node (.dev_val_i(txd), .dev_oe_i(oe), .drv_i(ndrv),
    .val_i(nval), .rx_val_i(rxv), .line_o(pin), .rx_line_o(rxpin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Timeout and hold run length monitor
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  always @(negedge clk) begin
    if (hold === 1'b1) run = run + 1;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end
  // ==========================================
  // Shared tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    integer n;
    reg ra, rw, b;
    begin
      @(posedge clk);
      awa <= a;
      wd <= {24'h000000, v};
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 40 && !b; n = n + 1) begin
        @(negedge clk);
        ra = awr;
        rw = wr_rdy;
        b = bv;
        resp = bresp;
        @(posedge clk);
        if (ra) awv <= 1'b0;
        if (rw) wv <= 1'b0;
      end
      brdy <= 1'b0;
      chk(b, 1'b1);
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    integer n;
    reg ra, r;
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      r = 1'b0;
      for (n = 0; n < 40 && !r; n = n + 1) begin
        @(negedge clk);
        ra = arr;
        r = rv;
        v = rdata[7:0];
        resp = rresp;
        @(posedge clk);
        if (ra) arv <= 1'b0;
      end
      rrdy <= 1'b0;
      chk(r, 1'b1);
    end
  endtask
  task waitfall;
    integer n;
    begin
      for (n = 0; n < 400 && hold !== 1'b0; n = n + 1) @(negedge clk);
      chk(hold, 1'b0);
      @(posedge clk);
    end
  endtask
  task pulse(input w, input m);
    begin
      @(posedge clk);
      wake <= !w;
      cdn <= w;
      cmsb <= m;
      @(posedge clk);
      wake <= 1'b0;
      cdn <= 1'b0;
      wt(2);
    end
  endtask
  // ==========================================
  // Scenarios
  task t_irq;
    begin
      rd(4'h8, d);
      for (i = 4; i < 8; i = i + 1) begin
        wr(4'h0, 8'h01 << i);
        wt(2);
        chk(irq, i > 5);
      end
      rd(4'h0, d);
      chk(d, 8'h80);
      @(posedge clk);
      full <= 1'b1;
      quiet <= 1'b1;
      wr(4'h0, 8'h20);
      wt(2);
      chk(irq, 1'b1);
      wr(4'h0, 8'h10);
      wt(2);
      chk(irq, 1'b1);
      wr(4'h0, 8'h00);
      wt(2);
      chk(irq, 1'b0);
      @(posedge clk);
      full <= 1'b0;
      quiet <= 1'b0;
      rd(4'h8, d);
      chk(d, 8'h30);
      rd(4'h8, d);
      chk(d, 8'h00);
      $display("irq test done");
    end
  endtask
  task t_tx;
    begin
      wr(4'h0, 8'h08);
      wt(2);
      chk({oe, gpio}, 2'b10);
      chk({hold, txd, done}, 3'b110);
      waitfall;
      chk(last_run, 10 * BD);
      wt(2);
      chk(done, 1'b1);
      wr(4'h4, 8'h08);
      wr(4'h0, 8'h09);
      wr(4'h0, 8'h00);
      wt(0);
      chk({hold, txd, oe}, 3'b101);
      waitfall;
      chk(last_run, 11 * BD);
      wt(2);
      chk({oe, gpio}, 2'b01);
      wr(4'h0, 8'h09);
      wt(150);
      chk({hold, txd}, 2'b10);
      wr(4'h0, 8'h08);
      waitfall;
      wr(4'h0, 8'h00);
      waitfall;
      $display("tx test done");
    end
  endtask
  task t_pins;
    begin
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h08);
      wt(1);
      chk({oe, gpio}, 2'b01);
      wr(4'h4, 8'h07);
      wt(1);
      chk({oe, rxl}, {1'b1, txd});
      wr(4'h4, 8'h03);
      ndrv <= 1'b1;
      nval <= 1'b0;
      wt(1);
      chk({oe, rxl}, 2'b00);
      wr(4'h4, 8'h00);
      ndrv <= 1'b0;
      rxv <= 1'b0;
      wt(1);
      chk(rxl, 1'b0);
      rxv <= 1'b1;
      wr(4'h0, 8'h00);
      waitfall;
      $display("pin test done");
    end
  endtask
  task t_rx;
    begin
      chk(rxg, 1'b1);
      wr(4'h0, 8'h06);
      wt(1);
      chk({rxg, rxe, stby}, 3'b011);
      pulse(1'b1, 1'b1);
      chk(stby, 1'b1);
      pulse(1'b0, 1'b0);
      chk(stby, 1'b0);
      wr(4'h4, 8'h10);
      wr(4'h0, 8'h06);
      pulse(1'b0, 1'b0);
      chk(stby, 1'b1);
      pulse(1'b1, 1'b0);
      chk(stby, 1'b1);
      pulse(1'b1, 1'b1);
      chk(stby, 1'b0);
      wr(4'h0, 8'h00);
      wt(1);
      chk(rxg, 1'b1);
      $display("rx test done");
    end
  endtask
  task t_bus;
    begin
      wr(4'h0, 8'h30);
      chk(resp, 2'h0);
      wr(4'h1, 8'hff);
      chk(resp, 2'h2);
      rd(4'h1, d);
      chk(resp, 2'h2);
      chk(d, 8'h00);
      rd(4'h0, d);
      chk(d, 8'h30);
      chk(resp, 2'h0);
      rd(4'h4, d);
      chk(d, 8'h10);
      wr(4'h0, 8'h00);
      $display("bus test done");
    end
  endtask
  task t_busy;
    begin
      @(posedge clk);
      busy <= 1'b1;
      shift <= 1'b0;
      wr(4'h0, 8'h08);
      wr(4'h0, 8'h00);
      wt(2);
      chk({oe, hold, txd, done}, 4'h8);
      rd(4'hc, d);
      chk(d, 8'h88);
      wr(4'h0, 8'h08);
      @(posedge clk);
      busy <= 1'b0;
      shift <= 1'b1;
      wt(3);
      chk({hold, txd, oe}, 3'b111);
      waitfall;
      chk(last_run, 10 * BD);
      wr(4'h0, 8'h00);
      wt(2);
      chk({oe, gpio, done}, 3'b011);
      $display("busy test done");
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {errors, checked, cyc, run, last_run} = 0;
    {rstn, awv, wv, brdy, arv, rrdy, full, quiet, wake, cdn} = 0;
    {cmsb, ndrv, busy, awa, ara, wd} = 0;
    {emp, nval, rxv, shift} = 4'hf;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wt(0);
    chk({done, oe, gpio, rxg, hold, irq}, 6'h2c);
    t_irq;
    t_tx;
    t_pins;
    t_rx;
    t_bus;
    t_busy;
    print_verdict;
  end
endmodule
